// *** include/sdspc_pkg.sv ***
// constants for the system dma standby and pause control block
// ----------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------
// Functional notes
// - three policies: never, forced, auto standby.
// - on-the-fly disable must finish drain first.
// - drain hazard: source sync, buffering, auto.
// - descriptor pointer bit 7 pauses descriptor load.
// - pause clear in standby must not hang.
// - status 15 or control 7 low: done.
package sdspc_pkg;
  localparam int unsigned NCH = 4;
  localparam logic [7:0] A_GCTRL = 8'h00;
  localparam logic [7:0] A_GSTAT = 8'h04;
  localparam logic [7:0] A_CH0 = 8'h10;
  localparam logic [3:0] CH_STRIDE_SH = 4'h4;
  localparam logic [3:0] O_CCR = 4'h0;
  localparam logic [3:0] O_CSR = 4'h4;
  localparam logic [3:0] O_CDP = 4'h8;
  localparam int unsigned CCR_EN = 7;
  localparam int unsigned CCR_SRC = 8;
  localparam int unsigned CCR_BUF = 9;
  localparam int unsigned CCR_DRAIN = 10;
  localparam int unsigned CSR_LOAD = 15;
  localparam int unsigned CSR_DRAIN = 14;
  localparam int unsigned CDP_PAUSE = 7;
  localparam logic [1:0] POL_FORCE = 2'h0;
  localparam logic [1:0] POL_NEVER = 2'h1;
  localparam logic [1:0] POL_AUTO = 2'h2;
  localparam logic [7:0] DRAIN_CYC = 8'h10;
  localparam logic [7:0] LOAD_CYC = 8'h08;
  typedef enum logic [1:0] {SDS_RUN, SDS_REQ, SDS_STBY} sdspc_st_t;
endpackage

// *** design/sdspc_cnt.sv ***
// per-channel countdown timer with registered count
`timescale 1ns/1ps
module sdspc_cnt
  import sdspc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       load_i,
  input  wire logic [7:0] val_i,
  input  wire logic       run_i,
  // status
  output logic            busy_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = val_i;
    end else if (run_i && cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign busy_o = (cnt_q != 8'h00);
endmodule

// *** design/sdspc_top.sv ***
// standby handshake and descriptor pause control with wishbone slave
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sdspc_top
  import sdspc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // power manager handshake
  input  wire logic        stby_ack_i,
  input  wire logic        wake_i,
  output logic             stby_req_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]  pol_q, pol_d;
  logic [15:0] ccr_q [NCH];
  logic [15:0] ccr_d [NCH];
  logic [NCH-1:0] pause_q, pause_d;
  logic [NCH-1:0] drn_ld, ld_ld, drn_busy, ld_busy;
  logic [NCH-1:0] ld_pend_q, ld_pend_d;
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic        req_q, req_d;
  sdspc_st_t   st_q, st_d;
  logic        busy;
  logic        acc;
  logic [7:0]  rel;
  logic [1:0]  ch;
  logic        ch_hit;
  logic [NCH-1:0] en_v;

  function automatic logic [15:0] wmask(input logic [15:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [15:0] r;
    r = o;
    if (s[0]) r[7:0] = n[7:0];
    if (s[1]) r[15:8] = n[15:8];
    return r;
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !ack_q;

  // channel window starts at the first channel base
  assign rel = wb_adr_i - A_CH0;
  assign ch = rel[5:4];
  assign ch_hit = (wb_adr_i >= A_CH0) && (rel[7:6] == 2'h0);

  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    assign en_v[g] = ccr_q[g][CCR_EN];
    sdspc_cnt u_drn (
      .mclk_i (mclk_i),
      .rst_b_i(rst_b_i),
      .load_i (drn_ld[g]),
      .val_i  (DRAIN_CYC),
      .run_i  (st_q != SDS_STBY),
      .busy_o (drn_busy[g])
    );
    sdspc_cnt u_ld (
      .mclk_i (mclk_i),
      .rst_b_i(rst_b_i),
      .load_i (ld_ld[g]),
      .val_i  (LOAD_CYC),
      .run_i  (st_q != SDS_STBY),
      .busy_o (ld_busy[g])
    );
  end

  // ----------------------------------------------------------------
  // register file and channel control
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] nw;
    nw = 16'h0000;
    pol_d = pol_q;
    pause_d = pause_q;
    ld_pend_d = ld_pend_q;
    drn_ld = '0;
    ld_ld = '0;
    ack_d = acc;
    rd_d = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      ccr_d[i] = ccr_q[i];
      // deferred load resumes once awake
      if (ld_pend_q[i] && st_q == SDS_RUN) begin
        ld_pend_d[i] = 1'b0;
        ld_ld[i] = 1'b1;
      end
    end
    if (acc && wb_adr_i == A_GCTRL) begin
      if (wb_we_i && wb_sel_i[0]) pol_d = wb_dat_i[1:0];
      rd_d = {30'h0, pol_q};
    end else if (acc && wb_adr_i == A_GSTAT) begin
      rd_d = {24'h0, ld_busy, drn_busy};
    end else if (acc && ch_hit) begin
      case (rel[3:0])
        O_CCR: begin
          rd_d = {16'h0, ccr_q[ch]};
          if (wb_we_i) begin
            nw = wmask(ccr_q[ch], wb_dat_i, wb_sel_i);
            // disabling on the fly with the drain bit set starts a drain
            if (ccr_q[ch][CCR_EN] && !nw[CCR_EN] && nw[CCR_DRAIN]) begin
              drn_ld[ch] = 1'b1;
            end
            ccr_d[ch] = nw;
          end
        end
        O_CSR: begin
          rd_d = 32'h0;
          rd_d[CSR_LOAD] = ld_busy[ch] | ld_pend_q[ch];
          rd_d[CSR_DRAIN] = drn_busy[ch];
        end
        O_CDP: begin
          rd_d = {24'h0, pause_q[ch], 7'h0};
          if (wb_we_i && wb_sel_i[0]) begin
            pause_d[ch] = wb_dat_i[CDP_PAUSE];
            if (pause_q[ch] && !wb_dat_i[CDP_PAUSE]) begin
              if (st_q == SDS_RUN) ld_ld[ch] = 1'b1;
              else ld_pend_d[ch] = 1'b1;
            end
          end
        end
        default: rd_d = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // standby handshake
  // ----------------------------------------------------------------
  always_comb begin
    busy = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      // drain counts as activity whatever sync or buffering mode
      busy = busy | ccr_q[i][CCR_EN] | drn_busy[i] | ld_busy[i]
           | ld_pend_q[i];
    end
    st_d = st_q;
    req_d = 1'b0;
    case (st_q)
      SDS_RUN: begin
        if (pol_q == POL_FORCE || (pol_q == POL_AUTO && !busy)) begin
          st_d = SDS_REQ;
        end
      end
      SDS_REQ: begin
        req_d = 1'b1;
        if (pol_q == POL_NEVER || (pol_q == POL_AUTO && busy)) begin
          st_d = SDS_RUN;
        end else if (stby_ack_i) begin
          st_d = SDS_STBY;
        end
      end
      SDS_STBY: begin
        req_d = 1'b1;
        if (wake_i || pol_q == POL_NEVER || |ld_pend_q
            || (pol_q == POL_AUTO && busy)) begin
          st_d = SDS_RUN;
          req_d = 1'b0;
        end
      end
      default: st_d = SDS_RUN;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pol_q <= POL_NEVER;
      pause_q <= '0;
      ld_pend_q <= '0;
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      st_q <= SDS_RUN;
      req_q <= 1'b0;
      for (int i = 0; i < NCH; i++) ccr_q[i] <= 16'h0000;
    end else begin
      pol_q <= pol_d;
      pause_q <= pause_d;
      ld_pend_q <= ld_pend_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      st_q <= st_d;
      req_q <= req_d;
      for (int i = 0; i < NCH; i++) ccr_q[i] <= ccr_d[i];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign stby_req_o = req_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_drain_start;
    |drn_ld;
  endsequence
  sequence s_pause_clear;
    |($past(pause_q) & ~pause_q);
  endsequence
  a_drain_blocks_stby: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) |drn_busy && pol_q == POL_AUTO
    && st_q == SDS_RUN |=> st_q != SDS_REQ)
    else $error("standby entered during drain");
  a_drain_busy_next: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) s_drain_start |=> |drn_busy)
    else $error("drain did not start");
  a_never_no_req: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) pol_q == POL_NEVER [*2] |=> !stby_req_o)
    else $error("request under never policy");
  a_force_req: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) pol_q == POL_FORCE && st_q == SDS_RUN
    |=> ##1 stby_req_o)
    else $error("force policy gave no request");
  a_auto_idle: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) st_q == SDS_REQ && $past(st_q) == SDS_RUN
    && $past(pol_q) == POL_AUTO
    |-> $past({en_v, drn_busy, ld_busy, ld_pend_q}) == '0)
    else $error("auto request while busy");
  a_pause_clear_run: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) s_pause_clear |-> ##[0:3] |ld_busy)
    else $error("paused channel hung");
  a_pause_bit: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) acc && wb_we_i && wb_sel_i[0] && ch_hit
    && rel[3:0] == O_CDP |=> pause_q[$past(ch)]
    == $past(wb_dat_i[CDP_PAUSE]))
    else $error("pause bit not stored");
  a_ack_one: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

// *** tb/sdspc_pm_model.sv ***
// power manager model answering the standby handshake
`timescale 1ns/1ps
module sdspc_pm_model (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // handshake
  input  wire logic req_i,
  input  wire logic slow_i,
  input  wire logic wake_req_i,
  output logic      ack_o,
  output logic      wake_o
);
  logic [3:0] cnt_q;
  // grant after a short or long delay, hold while requested
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_q  <= 4'h0;
      ack_o  <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_req_i;
      if (!req_i) begin
        cnt_q <= 4'h0;
        ack_o <= 1'b0;
      end else if (cnt_q >= (slow_i ? 4'hC : 4'h1)) begin
        ack_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// *** tb/sdspc_top_tb.sv ***
// testbench for the standby and pause control block
`timescale 1ns/1ps
module sdspc_top_tb
  import sdspc_pkg::*;
;
  logic        mclk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        stby_ack_i, wake_i, stby_req_o, wb_ack_o, slow, wake_req;
  logic [7:0]  wb_adr_i, a;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [63:0] ent;
  logic [63:0] expq[$];
  int          fails, checks;

  sdspc_top i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stby_ack_i(stby_ack_i), .wake_i(wake_i),
    .stby_req_o(stby_req_o));
  sdspc_pm_model i_pm (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .req_i(stby_req_o), .slow_i(slow), .wake_req_i(wake_req),
    .ack_o(stby_ack_i), .wake_o(wake_i));

  always #5 mclk_i = ~mclk_i;

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus cycles and waits
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d, input logic [31:0] m,
                    input logic [31:0] e, output logic [31:0] r);
    int k;
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    if (!we) expq.push_back({m, e});
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (k >= 20) begin
      fails++;
      print_verdict;
    end
  endtask

  task automatic wait_req(input logic v, input int lim);
    int k;
    k = 0;
    while (stby_req_o !== v && k < lim) begin
      @(posedge mclk_i);
      k++;
    end
    check({31'h0, stby_req_o}, {31'h0, v});
    if (k >= lim) print_verdict;
  endtask

  // poll a status bit until it clears, bounded
  task automatic poll(input logic [7:0] ad, input int b);
    int k;
    k = 0;
    do begin
      wb(1'b0, ad, 32'h0, 32'h0, 32'h0, rd);
      k++;
    end while (rd[b] !== 1'b0 && k < 30);
    check(rd & (32'h1 << b), 32'h0);
  endtask

  always @(posedge mclk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      ent = expq.pop_front();
      if (ent[63:32] != 32'h0) check(wb_dat_o & ent[63:32], ent[31:0]);
    end
  end

  initial begin
    {mclk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, slow, wake_req} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    fails = 0;
    checks = 0;
    rd = $urandom(74);
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    check({31'h0, stby_req_o}, 32'h0);
    wb(1'b0, A_GCTRL, 32'h0, 32'h3, {30'h0, POL_NEVER}, rd);
    a = 8'hC0 | 8'($urandom & 32'h3C);
    wb(1'b1, a, $urandom, 32'h0, 32'h0, rd);
    wb(1'b0, a, 32'h0, 32'hFFFFFFFF, 32'h0, rd);
    wb(1'b1, A_CH0 + O_CDP, 32'h80, 32'h0, 32'h0, rd);
    wb(1'b1, A_CH0 + O_CCR, 32'h780, 32'h0, 32'h0, rd);
    slow <= 1'($urandom);
    wb(1'b1, A_GCTRL, {30'h0, POL_AUTO}, 32'h0, 32'h0, rd);
    repeat (10) begin
      @(posedge mclk_i);
      check({31'h0, stby_req_o}, 32'h0);
    end
    wb(1'b1, A_CH0 + O_CCR, 32'h700, 32'h0, 32'h0, rd);
    wb(1'b0, A_GSTAT, 32'h0, 32'h1, 32'h1, rd);
    wb(1'b0, A_CH0 + O_CSR, 32'h0, 32'h4000, 32'h4000, rd);
    wb(1'b0, A_CH0 + O_CCR, 32'h0, 32'h80, 32'h0, rd);
    check({31'h0, stby_req_o}, 32'h0);
    wait_req(1'b1, 60);
    wb(1'b0, A_GSTAT, 32'h0, 32'hFF, 32'h0, rd);
    repeat (16) @(posedge mclk_i);
    wake_req <= 1'b1;
    @(posedge mclk_i);
    wake_req <= 1'b0;
    wait_req(1'b0, 10);
    wait_req(1'b1, 40);
    repeat (16) @(posedge mclk_i);
    wb(1'b1, A_CH0 + O_CDP, 32'h0, 32'h0, 32'h0, rd);
    wb(1'b0, A_CH0 + O_CSR, 32'h0, 32'h8000, 32'h8000, rd);
    poll(A_CH0 + O_CSR, CSR_LOAD);
    wait_req(1'b1, 40);
    wb(1'b1, A_CH0 + 8'h10, 32'h80, 32'h0, 32'h0, rd);
    wait_req(1'b0, 20);
    wb(1'b1, A_GCTRL, {30'h0, POL_FORCE}, 32'h0, 32'h0, rd);
    wait_req(1'b1, 30);
    wb(1'b1, A_GCTRL, {30'h0, POL_NEVER}, 32'h0, 32'h0, rd);
    wait_req(1'b0, 30);
    wb(1'b1, A_CH0 + 8'h10, 32'h780, 32'h0, 32'h0, rd);
    wb(1'b1, A_CH0 + 8'h10, 32'h700, 32'h0, 32'h0, rd);
    poll(A_CH0 + 8'h14, CSR_DRAIN);
    check({31'h0, stby_req_o}, 32'h0);
    wb(1'b1, A_GCTRL, {30'h0, POL_AUTO}, 32'h0, 32'h0, rd);
    wait_req(1'b1, 40);
    wb(1'b1, A_CH0 + 8'h18, 32'h80, 32'h0, 32'h0, rd);
    wb(1'b1, A_GCTRL, {30'h0, POL_NEVER}, 32'h0, 32'h0, rd);
    wait_req(1'b0, 30);
    wb(1'b1, A_CH0 + 8'h18, 32'h0, 32'h0, 32'h0, rd);
    poll(A_CH0 + 8'h14, CSR_LOAD);
    wb(1'b1, A_GCTRL, {30'h0, POL_AUTO}, 32'h0, 32'h0, rd);
    wait_req(1'b1, 40);
    print_verdict;
  end
endmodule
